/* File: common/sdp_pkg.sv */
// shared constants and types for the sdram pin protocol ends
package sdp_pkg;
    // =====================================
    // widths
    localparam int ROW_W = 12;
    localparam int COL_W = 8;
    localparam int BANK_W = 2;
    localparam int DQ_W = 16;
    localparam int MASK_W = 2;
    localparam int AP_BIT = 10;
    localparam int NBANK = 4;
    localparam int ROWS = 16;
    localparam int COLS = 16;
    // =====================================
    // timing
    localparam int CLK_MHZ = 250;
    localparam int PAUSE_US = 200;
    localparam int PAUSE_CYC = PAUSE_US * CLK_MHZ;
    localparam int READ_MASK_LAT = 2;
    localparam int CAS_LAT = 2;
    localparam int MODE_SET_RECOVERY_CYC = 2;
    localparam int PRECHARGE_CYC = 3;
    localparam int REFRESH_CYC = 8;
    localparam int INIT_REFRESH_COUNT = 8;
    localparam logic [3:0] REFRESH_COUNT_W4 = 4'h8;
    // =====================================
    // command codes {ras_n, cas_n, we_n}
    typedef enum logic [2:0] {
        SDP_CMD_MODE_SET = 3'b000,
        SDP_CMD_REFRESH = 3'b001,
        SDP_CMD_PRECHARGE = 3'b010,
        SDP_CMD_ACTIVATE = 3'b011,
        SDP_CMD_WRITE = 3'b100,
        SDP_CMD_READ = 3'b101,
        SDP_CMD_BURST_STOP = 3'b110,
        SDP_CMD_NOP = 3'b111
    } sdp_cmd_t;
    localparam logic [ROW_W-1:0] MODE_RESET = 12'h000;
endpackage

/* File: common/sdp_if.sv */
// pin-level link between the memory controller and the sdram device
`timescale 1ns/1ps
interface sdp_if;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic cke;
    logic [11:0] addr;
    logic [1:0] bank_pick;
    logic [1:0] dqm;
    logic [15:0] dq_from_ctl;
    logic dq_oe_ctl;
    logic [15:0] dq_from_mem;
    logic [1:0] dq_oe_mem;
    modport ctl (
        output cs_n, ras_n, cas_n, we_n, cke, addr, bank_pick, dqm, dq_from_ctl, dq_oe_ctl,
        input dq_from_mem, dq_oe_mem
    );
    modport mem (
        input cs_n, ras_n, cas_n, we_n, cke, addr, bank_pick, dqm, dq_from_ctl, dq_oe_ctl,
        output dq_from_mem, dq_oe_mem
    );
endinterface

/* File: src/sdp_mem.sv */
// sdram device end: command decode, masks, cke gating, small array
// What this block and sdp_ctl do
// - row twelve bits, column low eight bits
// - precharge with addr bit ten closes all
// - bank pick selects activate and access bank
// - chip select high ignores new commands
// - ras cas we decoded at rising edge
// - read mask floats byte two cycles later
// - write mask blocks byte same cycle
// - inputs captured only on rising edge
// - cke low enters power-down suspend self-refresh
// - mode register undefined until programmed (here reset loads 12'h000, mode_valid_out low)
// - command pins held nop during ramp
// - wait 200 us, then precharge all
// - masks and cke high during pause
// - after precharge all, set mode register
// - eight auto refreshes before normal access
// - sixteen data pins shared both directions
// - mode set is all strobes low
// - mode set needs banks idle, cke high
// - wait recovery delay after mode set
`timescale 1ns/1ps
module sdp_mem
    import sdp_pkg::*;
(
    // clock and reset
    input wire logic mclk_in,
    input wire logic sys_rst_in,
    // link
    sdp_if.mem pins,
    // status
    output logic mode_valid_out,
    output logic [1:0] low_power_out,
    output logic [3:0] bank_open_out
);
    import sdp_pkg::*;

    // =====================================
    // state
    logic [ROW_W-1:0] mode_reg;
    logic [ROW_W-1:0] open_row [NBANK];
    logic [NBANK-1:0] bank_open;
    // small array: bank x row low bits x column low bits
    logic [DQ_W-1:0] mem [NBANK][ROWS][COLS];
    logic prev_cke;
    logic rd_active;
    logic [BANK_W-1:0] rd_bank;
    logic [COL_W-1:0] rd_col;
    logic [DQ_W-1:0] rd_pipe [CAS_LAT];
    logic [CAS_LAT-1:0] rd_vld;
    logic [MASK_W-1:0] mask_pipe [READ_MASK_LAT];
    logic [DQ_W-1:0] dq_out;
    logic [MASK_W-1:0] dq_oe;
    sdp_cmd_t cmd;
    logic cmd_take;
    logic do_read;
    logic do_write;
    logic do_end_read;

    function automatic logic [3:0] idx4(input logic [ROW_W-1:0] a);
        return a[3:0];
    endfunction

    // =====================================
    // decode
    // deselected or clock stopped: command dropped, burst runs on only while cke is high
    always_comb begin
        cmd = sdp_cmd_t'({pins.ras_n, pins.cas_n, pins.we_n});
        cmd_take = !pins.cs_n && pins.cke && prev_cke;
        do_read = cmd_take && cmd == SDP_CMD_READ;
        do_write = cmd_take && cmd == SDP_CMD_WRITE;
        do_end_read = cmd_take && (cmd == SDP_CMD_WRITE || cmd == SDP_CMD_BURST_STOP
            || cmd == SDP_CMD_PRECHARGE);
    end

    // =====================================
    // cke tracking, low power state
    // cke falling: refresh gives self refresh, read gives suspend
    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            prev_cke <= 1'b1;
            low_power_out <= 2'h0;
        end else begin
            prev_cke <= pins.cke;
            if (!pins.cke && prev_cke) begin
                if (!pins.cs_n && cmd == SDP_CMD_REFRESH)
                    low_power_out <= 2'h3;
                else if (rd_active)
                    low_power_out <= 2'h2;
                else
                    low_power_out <= 2'h1;
            end else if (pins.cke) begin
                low_power_out <= 2'h0;
            end
        end
    end

    // =====================================
    // mode register and banks
    // mode set refused while any bank is open
    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            mode_reg <= MODE_RESET;
            mode_valid_out <= 1'b0;
            bank_open <= '0;
            bank_open_out <= 4'h0;
            for (int i = 0; i < NBANK; i++) begin
                open_row[i] <= '0;
            end
        end else begin
            if (cmd_take) begin
                case (cmd)
                    SDP_CMD_MODE_SET: begin
                        if (bank_open == '0) begin
                            mode_reg <= pins.addr;
                            mode_valid_out <= 1'b1;
                        end
                    end
                    SDP_CMD_ACTIVATE: begin
                        bank_open[pins.bank_pick] <= 1'b1;
                        open_row[pins.bank_pick] <= pins.addr;
                    end
                    SDP_CMD_PRECHARGE: begin
                        if (pins.addr[AP_BIT])
                            bank_open <= '0;
                        else
                            bank_open[pins.bank_pick] <= 1'b0;
                    end
                    default: begin
                    end
                endcase
            end
            bank_open_out <= bank_open;
        end
    end

    // =====================================
    // read and write column access
    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            rd_active <= 1'b0;
            rd_bank <= '0;
            rd_col <= '0;
        end else if (do_read) begin
            rd_active <= 1'b1;
            rd_bank <= pins.bank_pick;
            rd_col <= pins.addr[COL_W-1:0];
        end else if (do_end_read) begin
            rd_active <= 1'b0;
        end else if (rd_active && pins.cke) begin
            rd_col <= rd_col + 8'h01;
        end
    end

    // masked bytes keep their old contents, no latency
    always_ff @(posedge mclk_in) begin
        if (do_write && bank_open[pins.bank_pick]) begin
            for (int b = 0; b < MASK_W; b++) begin
                if (!pins.dqm[b])
                    mem[pins.bank_pick][idx4(open_row[pins.bank_pick])][pins.addr[3:0]][b*8 +: 8]
                        <= pins.dq_from_ctl[b*8 +: 8];
            end
        end
    end

    // =====================================
    // read data and mask latency pipes
    // whole pipe frozen while cke is low
    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            rd_vld <= '0;
            for (int i = 0; i < CAS_LAT; i++) begin
                rd_pipe[i] <= '0;
            end
            for (int i = 0; i < READ_MASK_LAT; i++) begin
                mask_pipe[i] <= '1;
            end
            dq_out <= '0;
        end else if (pins.cke) begin
            rd_pipe[0] <= mem[rd_bank][idx4(open_row[rd_bank])][rd_col[3:0]];
            rd_vld[0] <= rd_active;
            mask_pipe[0] <= pins.dqm;
            for (int i = 1; i < CAS_LAT; i++) begin
                rd_pipe[i] <= rd_pipe[i-1];
                rd_vld[i] <= rd_vld[i-1];
            end
            for (int i = 1; i < READ_MASK_LAT; i++) begin
                mask_pipe[i] <= mask_pipe[i-1];
            end
            dq_out <= rd_pipe[CAS_LAT-1];
        end
    end

    // =====================================
    // per-byte output enable
    // each byte follows its own mask bit from two edges back
    for (genvar g = 0; g < MASK_W; g++) begin : g_byte_oe
        always_ff @(posedge mclk_in or posedge sys_rst_in) begin
            if (sys_rst_in) begin
                dq_oe[g] <= 1'b0;
            end else if (pins.cke) begin
                dq_oe[g] <= rd_vld[CAS_LAT-1] && !mask_pipe[READ_MASK_LAT-1][g];
            end
        end
    end

    assign pins.dq_from_mem = dq_out;
    assign pins.dq_oe_mem = dq_oe;
endmodule

/* File: src/sdp_ctl.sv */
// controller end: power-up initialization and command issue
`timescale 1ns/1ps
module sdp_ctl
    import sdp_pkg::*;
#(
    parameter int CLK_MHZ_P = CLK_MHZ,
    parameter int PAUSE_CYC_P = PAUSE_US * CLK_MHZ_P
)(
    // clock and reset
    input wire logic mclk_in,
    input wire logic sys_rst_in,
    // mode value to program
    input wire logic [11:0] mode_value_in,
    // link
    sdp_if.ctl pins,
    // status
    output logic init_done_out
);
    import sdp_pkg::*;

    typedef enum logic [2:0] {
        SDP_ST_PAUSE = 3'b000,
        SDP_ST_PRECHARGE = 3'b001,
        SDP_ST_PRE_WAIT = 3'b010,
        SDP_ST_MODE = 3'b011,
        SDP_ST_MODE_WAIT = 3'b100,
        SDP_ST_REFRESH = 3'b101,
        SDP_ST_REF_WAIT = 3'b110,
        SDP_ST_DONE = 3'b111
    } sdp_init_t;

    sdp_init_t state;
    logic [31:0] wait_cnt;
    logic [3:0] ref_cnt;

    // =====================================
    // init sequencer
    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            state <= SDP_ST_PAUSE;
            wait_cnt <= '0;
            ref_cnt <= 4'h0;
            init_done_out <= 1'b0;
            pins.cs_n <= 1'b0;
            {pins.ras_n, pins.cas_n, pins.we_n} <= SDP_CMD_NOP;
            pins.cke <= 1'b1;
            pins.dqm <= 2'h3;
            pins.addr <= '0;
            pins.bank_pick <= '0;
            pins.dq_from_ctl <= '0;
            pins.dq_oe_ctl <= 1'b0;
        end else begin
            {pins.ras_n, pins.cas_n, pins.we_n} <= SDP_CMD_NOP;
            wait_cnt <= wait_cnt + 32'h1;
            case (state)
                SDP_ST_PAUSE: begin
                    if (wait_cnt >= 32'(PAUSE_CYC_P - 1)) begin
                        state <= SDP_ST_PRECHARGE;
                    end
                end
                SDP_ST_PRECHARGE: begin
                    {pins.ras_n, pins.cas_n, pins.we_n} <= SDP_CMD_PRECHARGE;
                    pins.addr <= 12'h400;
                    wait_cnt <= '0;
                    state <= SDP_ST_PRE_WAIT;
                end
                SDP_ST_PRE_WAIT: begin
                    if (wait_cnt >= 32'(PRECHARGE_CYC - 1))
                        state <= SDP_ST_MODE;
                end
                SDP_ST_MODE: begin
                    {pins.ras_n, pins.cas_n, pins.we_n} <= SDP_CMD_MODE_SET;
                    pins.addr <= mode_value_in;
                    wait_cnt <= '0;
                    state <= SDP_ST_MODE_WAIT;
                end
                SDP_ST_MODE_WAIT: begin
                    if (wait_cnt >= 32'(MODE_SET_RECOVERY_CYC - 1))
                        state <= SDP_ST_REFRESH;
                end
                SDP_ST_REFRESH: begin
                    {pins.ras_n, pins.cas_n, pins.we_n} <= SDP_CMD_REFRESH;
                    ref_cnt <= ref_cnt + 4'h1;
                    wait_cnt <= '0;
                    state <= SDP_ST_REF_WAIT;
                end
                SDP_ST_REF_WAIT: begin
                    if (wait_cnt >= 32'(REFRESH_CYC - 1))
                        state <= (ref_cnt == REFRESH_COUNT_W4) ? SDP_ST_DONE : SDP_ST_REFRESH;
                end
                SDP_ST_DONE: begin
                    init_done_out <= 1'b1;
                    pins.dqm <= 2'h0;
                end
                default: state <= SDP_ST_PAUSE;
            endcase
        end
    end
endmodule

/* File: testbench/sdp_props.sv */
// power-up sequence checks on the controller-to-device link
`timescale 1ns/1ps
module sdp_props
    import sdp_pkg::*;
#(
    parameter int PAUSE_P = 20
)(
    // clock and reset
    input wire logic mclk_in,
    input wire logic sys_rst_in,
    // link
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic cke,
    input wire logic [11:0] addr,
    input wire logic [1:0] dqm,
    input wire logic dq_oe_ctl,
    input wire logic [1:0] dq_oe_mem,
    // status
    input wire logic init_done_out
);
    // =====
    // helper counters
    logic [2:0] cmd;
    int cyc;
    int ref_cnt;
    assign cmd = {ras_n, cas_n, we_n};
    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            cyc <= 0;
        end else if (cyc < 100000) begin
            cyc <= cyc + 1;
        end
    end
    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            ref_cnt <= 0;
        end else if (!cs_n && cmd == SDP_CMD_REFRESH) begin
            ref_cnt <= ref_cnt + 1;
        end
    end
    // =====
    // assertions
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (sys_rst_in);
    property p_quiet; cyc < PAUSE_P |-> cmd == SDP_CMD_NOP && dqm == 2'h3 && cke; endproperty
    a_quiet: assert property (p_quiet) else $error("pause not quiet");
    property p_pre_all; !cs_n && cmd == SDP_CMD_PRECHARGE && !init_done_out
        |-> cyc >= PAUSE_P && cyc <= PAUSE_P + 1 && addr[AP_BIT]; endproperty
    a_pre_all: assert property (p_pre_all) else $error("bad precharge all");
    property p_mode_next; !cs_n && cmd == SDP_CMD_PRECHARGE && !init_done_out
        |-> ##4 !cs_n && cmd == SDP_CMD_MODE_SET; endproperty
    a_mode_next: assert property (p_mode_next) else $error("no mode set");
    property p_recover; !cs_n && cmd == SDP_CMD_MODE_SET
        |=> (cmd == SDP_CMD_NOP) [*2] ##1 cmd == SDP_CMD_REFRESH; endproperty
    a_recover: assert property (p_recover) else $error("mode recovery broken");
    property p_cke_init; !init_done_out |-> cke; endproperty
    a_cke_init: assert property (p_cke_init) else $error("cke low in init");
    property p_done_ref; $rose(init_done_out) |-> ref_cnt == INIT_REFRESH_COUNT; endproperty
    a_done_ref: assert property (p_done_ref) else $error("refresh count wrong");
    property p_done_hold; init_done_out |=> init_done_out; endproperty
    a_done_hold: assert property (p_done_hold) else $error("done dropped");
    property p_dq_quiet; !init_done_out |-> dq_oe_mem == 2'h0 && !dq_oe_ctl; endproperty
    a_dq_quiet: assert property (p_dq_quiet) else $error("data bus driven in init");
endmodule

/* File: testbench/sdram_pin_protocol_init_tb.sv */
// bench: controller joined to device, second device driven directly
`timescale 1ns/1ps
module sdram_pin_protocol_init_tb;
    import sdp_pkg::*;
    localparam int PAUSE_P = 20;
    logic mclk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic [11:0] mode_value_in = 12'h000;
    logic init_done_out, mode_valid_out, mode_valid_b;
    logic [1:0] low_power_out, low_power_b, b, m, rm;
    logic [3:0] bank_open_out, bank_open_b;
    logic [7:0] col;
    logic [15:0] d0, d1;
    int err_total = 0;
    int n_compared = 0;
    sdp_if bus ();
    sdp_if bus_b ();
    always #2 mclk_in = ~mclk_in;
    sdp_ctl #(.PAUSE_CYC_P(PAUSE_P)) i_sdp_ctl (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in),
        .mode_value_in(mode_value_in), .pins(bus.ctl), .init_done_out(init_done_out));
    sdp_mem i_sdp_mem (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .pins(bus.mem),
        .mode_valid_out(mode_valid_out), .low_power_out(low_power_out), .bank_open_out(bank_open_out));
    sdp_mem i_sdp_mem_b (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .pins(bus_b.mem),
        .mode_valid_out(mode_valid_b), .low_power_out(low_power_b), .bank_open_out(bank_open_b));
    sdp_props #(.PAUSE_P(PAUSE_P)) i_sdp_props (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in),
        .cs_n(bus.cs_n), .ras_n(bus.ras_n), .cas_n(bus.cas_n), .we_n(bus.we_n), .cke(bus.cke),
        .addr(bus.addr), .dqm(bus.dqm), .dq_oe_ctl(bus.dq_oe_ctl), .dq_oe_mem(bus.dq_oe_mem),
        .init_done_out(init_done_out));
    // =====
    // helpers
    function automatic logic [15:0] wmask(input logic [1:0] k);
        return {{8{k[1]}}, {8{k[0]}}};
    endfunction
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic end_sim();
        $display("compared %0d errors %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic cmd(input logic cs, input logic [2:0] c, input logic [1:0] bk, input logic [11:0] a,
                       input logic [1:0] k = 2'h0, input logic [15:0] d = 16'h0, input logic ck = 1'b1);
        @(negedge mclk_in);
        {bus_b.cs_n, bus_b.ras_n, bus_b.cas_n, bus_b.we_n, bus_b.cke, bus_b.bank_pick, bus_b.addr, bus_b.dqm,
         bus_b.dq_from_ctl, bus_b.dq_oe_ctl} = {cs, c, ck, bk, a, k, d, c == SDP_CMD_WRITE};
        @(posedge mclk_in);
        #1;
    endtask
    task automatic idle(input int n);
        repeat (n) cmd(1'b0, SDP_CMD_NOP, 2'h0, 12'h0);
    endtask
    task automatic rd(input logic [1:0] k, input logic [15:0] exp);
        cmd(1'b0, SDP_CMD_READ, b, {4'h0, col});
        cmd(1'b0, SDP_CMD_NOP, b, 12'h0, k);
        repeat (2) idle(1);
        chk(bus_b.dq_oe_mem, {~k});
        chk(bus_b.dq_from_mem & wmask(~k), exp & wmask(~k));
        repeat (2) cmd(1'b0, SDP_CMD_NOP, b, 12'h0, 2'h0, 16'h0, 1'b0);
        chk(low_power_b, 2'h2);
        idle(2);
        cmd(1'b0, SDP_CMD_BURST_STOP, b, 12'h0);
    endtask
    // =====
    // main sequence
    initial begin
        {bus_b.cs_n, bus_b.ras_n, bus_b.cas_n, bus_b.we_n, bus_b.cke, bus_b.bank_pick, bus_b.addr, bus_b.dqm,
         bus_b.dq_from_ctl, bus_b.dq_oe_ctl} = {1'b1, SDP_CMD_NOP, 1'b1, 2'h0, 12'h0, 2'h3, 16'h0, 1'b0};
        void'($urandom(24092));
        mode_value_in = 12'($urandom);
        repeat (20) @(posedge mclk_in);
        @(negedge mclk_in);
        sys_rst_in = 1'b0;
        for (int i = 0; i < 1000 && init_done_out !== 1'b1; i++) @(posedge mclk_in);
        if (init_done_out !== 1'b1) begin
            err_total++;
            end_sim();
        end
        #1;
        chk(mode_valid_out, 1'b1);
        chk(bank_open_out, 4'h0);
        chk(low_power_out, 2'h0);
        $display("test init done");
        cmd(1'b0, SDP_CMD_ACTIVATE, 2'h1, 12'h005);
        cmd(1'b0, SDP_CMD_MODE_SET, 2'h0, 12'h023);
        idle(1);
        chk(bank_open_b, 4'h2);
        chk(mode_valid_b, 1'b0);
        cmd(1'b0, SDP_CMD_PRECHARGE, 2'h2, 12'h000);
        cmd(1'b1, SDP_CMD_ACTIVATE, 2'h3, 12'h000);
        idle(1);
        chk(bank_open_b, 4'h2);
        cmd(1'b0, SDP_CMD_PRECHARGE, 2'h0, 12'h400);
        idle(3);
        chk(bank_open_b, 4'h0);
        cmd(1'b0, SDP_CMD_MODE_SET, 2'h0, 12'h023);
        idle(2);
        chk(mode_valid_b, 1'b1);
        $display("test gating done");
        for (int i = 0; i < 2; i++) begin
            cmd(1'b0, i ? SDP_CMD_REFRESH : SDP_CMD_NOP, 2'h0, 12'h0, 2'h0, 16'h0, 1'b0);
            cmd(1'b0, SDP_CMD_NOP, 2'h0, 12'h0, 2'h0, 16'h0, 1'b0);
            chk(low_power_b, i ? 2'h3 : 2'h1);
            idle(3);
            chk(low_power_b, 2'h0);
            idle(8);
        end
        $display("test low power done");
        for (int k = 0; k < 6; k++) begin
            {b, col, m, rm, d0, d1} = 46'({$urandom, $urandom});
            if (k < 2) begin
                m = k ? 2'h0 : 2'h3;
                rm = k ? 2'h3 : 2'h0;
            end
            cmd(1'b0, SDP_CMD_ACTIVATE, b, 12'($urandom));
            idle(2);
            cmd(1'b0, SDP_CMD_WRITE, b, {4'h0, col}, 2'h0, d0);
            cmd(1'b0, SDP_CMD_BURST_STOP, b, 12'h0, 2'h3);
            cmd(1'b0, SDP_CMD_WRITE, b, {4'h0, col}, m, d1);
            cmd(1'b0, SDP_CMD_BURST_STOP, b, 12'h0, 2'h3);
            rd(rm, (d1 & wmask(~m)) | (d0 & wmask(m)));
            cmd(1'b0, SDP_CMD_PRECHARGE, b, 12'h400);
            idle(3);
            $display("test access %0d done", k);
        end
        end_sim();
    end
endmodule
